// [tvss_pkg.sv]
package tvss_pkg;
  // Video format selection
  localparam logic FMT_FOURTEEN_BIT_RAW_FORMAT = 1'b0;
  localparam logic FMT_RGB888 = 1'b1;
  // Stored start-up settings layout: [0] format, [1] sync pin mode, [9:2] sync offset, [10] tlinear, [11] tlin res
  localparam int SS_W = 12;
  localparam int SS_FMT_BIT = 0;
  localparam int SS_SYNC_BIT = 1;
  localparam int SS_OFS_LSB = 2;
  localparam int SS_OFS_W = 8;
  localparam int SS_TLIN_BIT = 10;
  localparam int SS_TRES_BIT = 11;
  // Factory defaults: fourteen_bit_raw_format, sync pin disabled, 0 line offset, tlinear on, 0.01 resolution
  localparam logic [11:0] SS_RESET = 12'hc00;
  localparam logic TRES_CENTI = 1'b1;
  // Packet geometry
  localparam int HDR_BYTES = 4;
  localparam logic [7:0] PAY_FOURTEEN_BIT_RAW_FORMAT = 8'ha0;
  localparam logic [7:0] PAY_RGB888 = 8'hf0;
  localparam logic [7:0] PKT_FOURTEEN_BIT_RAW_FORMAT = 8'ha4;
  localparam logic [7:0] PKT_RGB888 = 8'hf4;
  localparam logic [11:0] LINES_PER_FRAME = 12'h03c;
  localparam logic [3:0] DISCARD_NIB = 4'hf;
  localparam logic [15:0] CRC_POLY = 16'h1021;
endpackage

// [tvss_spi_slave.sv]
`timescale 1ns/1ps
// Functional notes
// - Start-up settings come from stored defaults; no configuration sequence is required.
// - Without stored overrides, video powers up in fourteen-bit raw format.
// - Sync pin mode powers up disabled with zero-line pulse offset.
// - Temperature-linear output powers up enabled at hundredth-degree resolution.
// - Video travels only as packets; no embedded timing, no host flow control.
// - Frame data is correct at host clock rates slow enough for CLOCK to sample every SCK edge with each SCK low phase over three CLOCK cycles, steady or bursting.
// - With clocking continuing after a frame, discard packets until new video.
// - Clock idles high; device shifts on falling edge, host samples rising.
// - Packets are four header bytes then 160 or 240 payload bytes.
// - Discard packets carry hex F in the identifier's second nibble.
module tvss_spi_slave (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic SCK,
  input wire logic CS_N,
  output logic MISO_O,
  output logic MISO_OE,
  input wire logic [11:0] STORED_SETTINGS,
  input wire logic STORED_VALID,
  input wire logic FRAME_READY,
  output logic FRAME_TAKEN,
  input wire logic [7:0] PIX_BYTE,
  output logic PIX_REQ,
  output logic [11:0] PIX_LINE,
  output logic [7:0] PIX_INDEX,
  output logic FMT_RGB,
  output logic SYNC_PIN_EN,
  output logic [7:0] SYNC_OFFSET,
  output logic TLINEAR_EN,
  output logic TLIN_CENTI,
  output logic BUSY
);
  typedef enum logic [1:0] {TVSS_IDLE, TVSS_DISCARD, TVSS_VIDEO} tvss_state_t;
  logic [2:0] sck_s_q, cs_s_q;
  logic [11:0] set_q;
  logic loaded_q;
  tvss_state_t st_q;
  logic [7:0] byte_cnt_q, sh_q, pkt_len;
  logic [2:0] bit_cnt_q;
  logic [11:0] line_q;
  logic [15:0] crc_q;
  logic fall, cs_act, pkt_end, byte_end;
  logic [7:0] next_byte;

  // Two-flop synchronisers, third stage for edge detection
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sck_s_q <= 3'h7;
      cs_s_q <= 3'h7;
    end else begin
      sck_s_q <= {sck_s_q[1:0], SCK};
      cs_s_q <= {cs_s_q[1:0], CS_N};
    end
  end
  assign cs_act = !cs_s_q[1];
  assign fall = cs_act && sck_s_q[2] && !sck_s_q[1];

  // Settings latched once after reset release
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      set_q <= tvss_pkg::SS_RESET;
      loaded_q <= 1'b0;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      if (STORED_VALID)
        set_q <= STORED_SETTINGS;
    end
  end
  assign pkt_len = set_q[tvss_pkg::SS_FMT_BIT] ? tvss_pkg::PKT_RGB888 : tvss_pkg::PKT_FOURTEEN_BIT_RAW_FORMAT;
  assign byte_end = fall && (bit_cnt_q == 3'h7);
  assign pkt_end = byte_end && (byte_cnt_q == pkt_len - 8'h01);

  // CRC update of one byte, MSB first; applied only to the two ID bytes with the top ID nibble zeroed
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
      r = (r[15] ^ b[i]) ? ((r << 1) ^ tvss_pkg::CRC_POLY) : (r << 1);
    return r;
  endfunction

  // Byte to emit next for the current state and position
  always_comb begin
    next_byte = 8'h00;
    if (st_q == TVSS_VIDEO) begin
      unique case (byte_cnt_q)
        8'h00: next_byte = {4'h0, line_q[11:8]};
        8'h01: next_byte = line_q[7:0];
        8'h02: next_byte = crc_q[15:8];
        8'h03: next_byte = crc_q[7:0];
        default: next_byte = PIX_BYTE;
      endcase
    end else if (byte_cnt_q == 8'h00) begin
      next_byte = {4'h0, tvss_pkg::DISCARD_NIB};
    end
  end

  // Packet sequencing: discard until a frame is ready, then lines from zero
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= TVSS_IDLE;
      line_q <= 12'h000;
      FRAME_TAKEN <= 1'b0;
    end else begin
      FRAME_TAKEN <= 1'b0;
      unique case (st_q)
        TVSS_IDLE: if (cs_act) st_q <= TVSS_DISCARD;
        TVSS_DISCARD: begin
          if (!cs_act) st_q <= TVSS_IDLE;
          else if (pkt_end && FRAME_READY) begin
            st_q <= TVSS_VIDEO;
            line_q <= 12'h000;
            FRAME_TAKEN <= 1'b1;
          end
        end
        TVSS_VIDEO: begin
          if (pkt_end) begin
            if (line_q == tvss_pkg::LINES_PER_FRAME - 12'h001)
              st_q <= TVSS_DISCARD;
            else
              line_q <= line_q + 12'h001;
          end
          if (!cs_act) st_q <= TVSS_IDLE;
        end
        default: st_q <= TVSS_IDLE;
      endcase
    end
  end

  // Bit and byte shifting on falling edges, MSB first
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 8'h00;
      sh_q <= 8'h00;
      MISO_O <= 1'b0;
      MISO_OE <= 1'b0;
    end else begin
      MISO_OE <= cs_act;
      if (!cs_act) begin
        bit_cnt_q <= 3'h0;
        byte_cnt_q <= 8'h00;
        MISO_O <= 1'b0;
      end else if (fall) begin
        if (bit_cnt_q == 3'h0) begin
          MISO_O <= next_byte[7];
          sh_q <= {next_byte[6:0], 1'b0};
        end else begin
          MISO_O <= sh_q[7];
          sh_q <= {sh_q[6:0], 1'b0};
        end
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (byte_end)
          byte_cnt_q <= pkt_end ? 8'h00 : byte_cnt_q + 8'h01;
      end
    end
  end
  // Header-only CRC with the top ID nibble zeroed; payload left out to avoid a line buffer
  // Refreshed every cycle so it always follows the line number being sent
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN)
      crc_q <= 16'h0000;
    else
      crc_q <= crc_byte(crc_byte(16'h0000, {4'h0, line_q[11:8]}), line_q[7:0]);
  end

  // Pixel fetch: request next payload byte as the previous byte's last bit shifts out, one bit ahead of its use
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      PIX_REQ <= 1'b0;
      PIX_LINE <= 12'h000;
      PIX_INDEX <= 8'h00;
    end else begin
      PIX_REQ <= (st_q == TVSS_VIDEO) && byte_end && (byte_cnt_q >= 8'h03) && !pkt_end;
      PIX_LINE <= line_q;
      PIX_INDEX <= byte_cnt_q - 8'(tvss_pkg::HDR_BYTES);
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      FMT_RGB <= tvss_pkg::FMT_FOURTEEN_BIT_RAW_FORMAT;
      SYNC_PIN_EN <= 1'b0;
      SYNC_OFFSET <= 8'h00;
      TLINEAR_EN <= 1'b1;
      TLIN_CENTI <= tvss_pkg::TRES_CENTI;
      BUSY <= 1'b0;
    end else begin
      FMT_RGB <= set_q[tvss_pkg::SS_FMT_BIT];
      SYNC_PIN_EN <= set_q[tvss_pkg::SS_SYNC_BIT];
      SYNC_OFFSET <= set_q[tvss_pkg::SS_OFS_LSB +: tvss_pkg::SS_OFS_W];
      TLINEAR_EN <= set_q[tvss_pkg::SS_TLIN_BIT];
      TLIN_CENTI <= set_q[tvss_pkg::SS_TRES_BIT];
      BUSY <= (st_q == TVSS_VIDEO);
    end
  end

  AST_OE_IDLE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    cs_s_q[2:1] == 2'b11 |=> !MISO_OE) else $error("output driven while deselected");
  AST_DEFAULTS: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $rose(loaded_q) && !$past(STORED_VALID) |=> set_q == tvss_pkg::SS_RESET) else $error("bad defaults");
  AST_START_ZERO: assert property (@(posedge CLOCK) disable iff (!RSTN)
    FRAME_TAKEN |-> line_q == 12'h000 && st_q == TVSS_VIDEO && byte_cnt_q == 8'h00)
    else $error("frame not at line zero");
  AST_DISCARD_ID: assert property (@(posedge CLOCK) disable iff (!RSTN)
    st_q == TVSS_DISCARD && byte_cnt_q == 8'h00 |-> next_byte[3:0] == 4'hf) else $error("discard id");
  AST_PKT_LEN: assert property (@(posedge CLOCK) disable iff (!RSTN)
    byte_cnt_q < pkt_len) else $error("packet length overrun");
  AST_NO_EDGE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !cs_act |=> byte_cnt_q == 8'h00 && bit_cnt_q == 3'h0) else $error("edges not ignored");
  AST_FRAME_END: assert property (@(posedge CLOCK) disable iff (!RSTN)
    st_q == TVSS_VIDEO && pkt_end && cs_act && line_q == tvss_pkg::LINES_PER_FRAME - 12'h001
    |=> st_q == TVSS_DISCARD) else $error("no discard");
  AST_FALL_SHIFT: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !fall && cs_act && $past(cs_act) |=> $stable(bit_cnt_q)) else $error("shift without falling edge");
  AST_PIX_INDEX: assert property (@(posedge CLOCK) disable iff (!RSTN)
    st_q == TVSS_VIDEO && fall && bit_cnt_q == 3'h0 && byte_cnt_q >= 8'(tvss_pkg::HDR_BYTES)
    |-> PIX_INDEX == byte_cnt_q - 8'(tvss_pkg::HDR_BYTES)) else $error("payload index misaligned");
  COV_FRAME: cover property (@(posedge CLOCK) FRAME_TAKEN);
  COV_END: cover property (@(posedge CLOCK) st_q == TVSS_VIDEO ##1 st_q == TVSS_DISCARD);
  COV_PAUSE: cover property (@(posedge CLOCK) st_q == TVSS_VIDEO ##1 st_q == TVSS_IDLE);
endmodule

// [tvss_host_model.sv]
`timescale 1ns/1ps
module tvss_host_model (
  output logic SCK,
  output logic CS_N,
  input wire logic MISO_O,
  input wire logic MISO_OE
);
  logic last = 1'b0;
  // Released line shows the inverse of the last bit, never stale data
  wire logic line = MISO_OE ? MISO_O : ~last;
  initial begin
    SCK = 1'b1;
    CS_N = 1'b1;
  end
  task automatic sel(input logic on);
    CS_N <= ~on;
    #200;
  endtask
  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      SCK <= 1'b0;
      #80;
      SCK <= 1'b1;
      b[i] = line;
      last = line;
      #80;
    end
  endtask
endmodule

// [thermal_video_spi_slave_tb_top.sv]
`timescale 1ns/1ps
module thermal_video_spi_slave_tb_top;
  logic CLOCK = 1'b0;
  logic RSTN = 1'b0;
  logic [11:0] STORED_SETTINGS = 12'h000;
  logic STORED_VALID = 1'b0;
  logic FRAME_READY = 1'b0;
  logic SCK, CS_N, MISO_O, MISO_OE, FRAME_TAKEN, PIX_REQ, FMT_RGB, SYNC_PIN_EN, TLINEAR_EN, TLIN_CENTI, BUSY;
  logic [11:0] PIX_LINE;
  logic [7:0] PIX_INDEX, SYNC_OFFSET, b;
  // Payload source: byte value is index xor line
  wire logic [7:0] PIX_BYTE = PIX_INDEX ^ PIX_LINE[7:0];
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int takes = 0;
  int reqs = 0;
  tvss_spi_slave tvss_spi_slave_i (.CLOCK(CLOCK), .RSTN(RSTN), .SCK(SCK), .CS_N(CS_N), .MISO_O(MISO_O),
    .MISO_OE(MISO_OE), .STORED_SETTINGS(STORED_SETTINGS), .STORED_VALID(STORED_VALID),
    .FRAME_READY(FRAME_READY), .FRAME_TAKEN(FRAME_TAKEN), .PIX_BYTE(PIX_BYTE), .PIX_REQ(PIX_REQ),
    .PIX_LINE(PIX_LINE), .PIX_INDEX(PIX_INDEX), .FMT_RGB(FMT_RGB), .SYNC_PIN_EN(SYNC_PIN_EN),
    .SYNC_OFFSET(SYNC_OFFSET), .TLINEAR_EN(TLINEAR_EN), .TLIN_CENTI(TLIN_CENTI), .BUSY(BUSY));
  tvss_host_model tvss_host_model_i (.SCK(SCK), .CS_N(CS_N), .MISO_O(MISO_O), .MISO_OE(MISO_OE));
  initial forever #5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (FRAME_TAKEN === 1'b1) takes <= takes + 1;
    if (PIX_REQ === 1'b1) reqs <= reqs + 1;
    if (cycles == 90000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic vld, input logic [11:0] s);
    @(posedge CLOCK);
    RSTN <= 1'b0;
    STORED_VALID <= vld;
    STORED_SETTINGS <= s;
    repeat (3) @(posedge CLOCK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLOCK);
    #1;
  endtask
  task automatic test_settings();
    do_reset(1'b0, 12'h3ff);
    chk("fmt", 16'(FMT_RGB), 16'h0000);
    chk("sync en", 16'(SYNC_PIN_EN), 16'h0000);
    chk("sync ofs", 16'(SYNC_OFFSET), 16'h0000);
    chk("tlin", 16'({TLINEAR_EN, TLIN_CENTI}), 16'h0003);
    chk("oe idle", 16'(MISO_OE), 16'h0000);
    do_reset(1'b1, 12'h2ab);
    chk("stored", 16'({TLIN_CENTI, TLINEAR_EN, SYNC_OFFSET, SYNC_PIN_EN, FMT_RGB}), 16'h02ab);
    do_reset(1'b0, 12'h000);
  endtask
  // Reads n bytes of a discard packet starting at byte position first
  task automatic read_disc(input int n, input int first);
    for (int k = first; k < first + n; k++) begin
      tvss_host_model_i.get_byte(b);
      if (k == 0) chk("discard id", 16'(b[3:0]), 16'h000f);
    end
  endtask
  task automatic read_line(input logic [11:0] ln, input int n);
    logic [7:0] e;
    for (int k = 0; k < n; k++) begin
      tvss_host_model_i.get_byte(b);
      e = (k == 0) ? {4'h0, ln[11:8]} : (k == 1) ? ln[7:0] : 8'(k - 4) ^ ln[7:0];
      if (k != 2 && k != 3) chk("pkt byte", 16'(b), 16'(e));
    end
  endtask
  task automatic test_stream();
    int r0;
    @(posedge CLOCK);
    FRAME_READY <= 1'b1;
    tvss_host_model_i.sel(1'b1);
    chk("oe sel", 16'(MISO_OE), 16'h0001);
    read_disc(164, 0);
    chk("taken", 16'(takes), 16'h0001);
    r0 = reqs;
    read_line(12'h000, 164);
    chk("pix req", 16'(reqs - r0), 16'h00a0);
    chk("busy", 16'(BUSY), 16'h0001);
    // Pause in mid-line, then resume with no frame pending
    read_line(12'h001, 8);
    @(posedge CLOCK);
    FRAME_READY <= 1'b0;
    tvss_host_model_i.sel(1'b0);
    chk("oe desel", 16'(MISO_OE), 16'h0000);
    chk("idle busy", 16'(BUSY), 16'h0000);
    tvss_host_model_i.sel(1'b1);
    read_disc(4, 0);
    @(posedge CLOCK);
    FRAME_READY <= 1'b1;
    read_disc(160, 4);
    chk("retaken", 16'(takes), 16'h0002);
    read_line(12'h000, 8);
    tvss_host_model_i.sel(1'b0);
  endtask
  initial begin
    test_settings();
    test_stream();
    conclude();
  end
endmodule
